// File: src/mie_pkg.sv
// constants and opcode set for the instruction execute subset
// Function
// - power-down sets powerdown flag, clears expiry flag
// - power-down halts, stops clock, clears watchdog
// - increment byte into memory or accumulator, zero only
// - branch loads address field, takes two cycles
// - copies between memory, immediate, accumulator; no flags
// - idle instruction changes nothing, just advances
// - or into accumulator or memory, zero only
// - return pops counter, immediate form loads accumulator
// - interrupt exit pops counter, sets global enable
// - pending interrupt served before resuming main program
// - left rotate, bit seven wraps to zero
// - left rotate through carry, only carry changes
// - right rotate, bit zero wraps to seven
// - right rotate through carry, only carry changes
// - accumulator rotates leave source byte untouched
// - subtract operand and inverted carry from accumulator
// - carry clear on negative, set otherwise
// - subtract updates six arithmetic flags
// - decrement byte, skip on zero, two cycles only when it skips
// - accumulator decrement form keeps memory, skips on result
// - fill byte writes all ones, no flags
// - set bit forces one bit, no flags
package mie_pkg;

  typedef logic [4:0] mie_op_t;

  localparam mie_op_t OP_IDLE = 5'h00;
  localparam mie_op_t OP_POWERDOWN = 5'h01;
  localparam mie_op_t OP_INC_MEM = 5'h02;
  localparam mie_op_t OP_INC_ACC = 5'h03;
  localparam mie_op_t OP_BRANCH = 5'h04;
  localparam mie_op_t OP_COPY_MEM_ACC = 5'h05;
  localparam mie_op_t OP_COPY_IMM_ACC = 5'h06;
  localparam mie_op_t OP_COPY_ACC_MEM = 5'h07;
  localparam mie_op_t OP_UNION_MEM_ACC = 5'h08;
  localparam mie_op_t OP_UNION_IMM_ACC = 5'h09;
  localparam mie_op_t OP_UNION_INTO_RAM = 5'h0a;
  localparam mie_op_t OP_POP_PC = 5'h0b;
  localparam mie_op_t OP_POP_PC_IMM = 5'h0c;
  localparam mie_op_t OP_INTERRUPT_EXIT = 5'h0d;
  localparam mie_op_t OP_ROTL_MEM = 5'h0e;
  localparam mie_op_t OP_ROTL_ACC = 5'h0f;
  localparam mie_op_t OP_ROTLC_MEM = 5'h10;
  localparam mie_op_t OP_ROTLC_ACC = 5'h11;
  localparam mie_op_t OP_ROTR_MEM = 5'h12;
  localparam mie_op_t OP_ROTR_ACC = 5'h13;
  localparam mie_op_t OP_ROTRC_MEM = 5'h14;
  localparam mie_op_t OP_ROTRC_ACC = 5'h15;
  localparam mie_op_t OP_SUBB_MEM_ACC = 5'h16;
  localparam mie_op_t OP_SUBB_IMM_ACC = 5'h17;
  localparam mie_op_t OP_SUBB_INTO_RAM = 5'h18;
  localparam mie_op_t OP_DEC_SKIP_MEM = 5'h19;
  localparam mie_op_t OP_DEC_SKIP_ACC = 5'h1a;
  localparam mie_op_t OP_FILL_BYTE = 5'h1b;
  localparam mie_op_t OP_SET_BIT = 5'h1c;

  typedef enum logic [2:0] {
    ST_EXEC = 3'b001,
    ST_DUMMY = 3'b010,
    ST_HALT = 3'b100
  } mie_state_t;

  // system clocks per instruction cycle
  localparam int CYCLE_DIV = 4;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] BYTE_ALL_ONES = 8'hff;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam int PC_STEP = 1;
  localparam int PC_SKIP_STEP = 2;

endpackage

// File: src/mie_cycle_div.sv
// divider giving one instruction-cycle enable pulse
`timescale 1ns/100ps
module mie_cycle_div #(
  parameter int DIV = mie_pkg::CYCLE_DIV
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // enable pulse
  output logic cyc_en
);
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic next_cyc_en;

  always_comb
  begin
    next_cnt = cnt + 8'h01;
    next_cyc_en = 1'b0;
    if (cnt == 8'(DIV - 1))
    begin
      next_cnt = 8'h00;
      next_cyc_en = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt <= 8'h00;
      cyc_en <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      cyc_en <= next_cyc_en;
    end
  end
endmodule // mie_cycle_div

// File: src/mie_sub_borrow.sv
// 8-bit subtractor with borrow and arithmetic flag outputs
`timescale 1ns/100ps
module mie_sub_borrow (
  // operands
  input wire logic [7:0] minuend,
  input wire logic [7:0] subtrahend,
  input wire logic carry_in,
  // result and flags
  output logic [7:0] diff,
  output logic carry_out,
  output logic half_out,
  output logic wrap_out,
  output logic signed_out
);
  logic [8:0] full;
  logic [4:0] low;

  // a - b - !c done as a + ~b + c, so carry out means no borrow
  always_comb
  begin
    full = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, carry_in};
    low = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, carry_in};
    diff = full[7:0];
    carry_out = full[8];
    half_out = low[4];
    wrap_out = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ full[7]);
    // sign of the true result, valid even when the byte wrapped
    signed_out = full[7] ^ wrap_out;
  end
endmodule // mie_sub_borrow

// File: src/mie_exec.sv
// execute stage for the power-down, move, or, return, rotate, subtract and set group
`timescale 1ns/100ps
module mie_exec #(
  parameter int PC_W = 13,
  parameter int MA_W = 9,
  parameter logic [12:0] IRQ_VECTOR = 13'h0004
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // decoded instruction
  input wire logic instr_valid,
  input wire logic [4:0] instr_op,
  input wire logic [PC_W-1:0] instr_addr,
  input wire logic [MA_W-1:0] instr_mem_addr,
  input wire logic [7:0] instr_imm,
  input wire logic [2:0] instr_bit,
  // data memory and stack
  input wire logic [7:0] mem_rdata,
  input wire logic [PC_W-1:0] stack_top,
  // interrupt and wake
  input wire logic irq_pending,
  input wire logic wake,
  // architectural state
  output logic [PC_W-1:0] pc,
  output logic [7:0] acc,
  output logic carry_flag,
  output logic zero_flag,
  output logic half_carry_flag,
  output logic arith_wrap_flag,
  output logic signed_result_flag,
  output logic chained_zero_flag,
  output logic powerdown_flag,
  output logic wdt_expired_flag,
  output logic global_irq_enable,
  // memory and stack strobes
  output logic mem_we,
  output logic [MA_W-1:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic stack_pop,
  output logic stack_push,
  output logic [PC_W-1:0] stack_push_data,
  // status strobes
  output logic instr_taken,
  output logic dummy_cycle,
  output logic clock_stop,
  output logic wdt_clear,
  output logic irq_ack
);
  localparam int SVC_WAIT = 16;

  mie_pkg::mie_state_t state, next_state;
  logic cyc_en;
  logic go;
  logic svc_pending, next_svc_pending;
  logic [PC_W-1:0] next_pc;
  logic [7:0] next_acc;
  logic next_carry, next_zero, next_half, next_wrap, next_signed, next_chain;
  logic next_pdf, next_wdt_exp, next_gie;
  logic next_mem_we, next_stack_pop, next_stack_push, next_taken, next_irq_ack;
  logic next_wdt_clear;
  logic [MA_W-1:0] next_mem_addr;
  logic [7:0] next_mem_wdata;
  logic [PC_W-1:0] next_push_data;
  logic [7:0] sub_b, sub_diff, inc_val, dec_val, bit_mask;
  logic sub_c, sub_h, sub_w, sub_s, sub_dest_ram;

  mie_cycle_div #(
    .DIV(mie_pkg::CYCLE_DIV)
  ) u_div (
    .clk(clk),
    .nrst(nrst),
    .cyc_en(cyc_en)
  );

  mie_sub_borrow u_sub (
    .minuend(acc),
    .subtrahend(sub_b),
    .carry_in(carry_flag),
    .diff(sub_diff),
    .carry_out(sub_c),
    .half_out(sub_h),
    .wrap_out(sub_w),
    .signed_out(sub_s)
  );

  // instructions are only taken on an instruction-cycle edge
  assign go = (state == mie_pkg::ST_EXEC) && cyc_en && instr_valid;
  assign sub_b = (instr_op == mie_pkg::OP_SUBB_IMM_ACC) ? instr_imm : mem_rdata;
  assign sub_dest_ram = (instr_op == mie_pkg::OP_SUBB_INTO_RAM);
  assign inc_val = mem_rdata + mie_pkg::BYTE_ONE;
  assign dec_val = mem_rdata - mie_pkg::BYTE_ONE;
  assign bit_mask = mie_pkg::BYTE_ONE << instr_bit;

  always_comb
  begin
    next_state = state;
    next_svc_pending = svc_pending;
    next_pc = pc;
    next_acc = acc;
    next_carry = carry_flag;
    next_zero = zero_flag;
    next_half = half_carry_flag;
    next_wrap = arith_wrap_flag;
    next_signed = signed_result_flag;
    next_chain = chained_zero_flag;
    next_pdf = powerdown_flag;
    next_wdt_exp = wdt_expired_flag;
    next_gie = global_irq_enable;
    next_mem_we = 1'b0;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    next_stack_pop = 1'b0;
    next_stack_push = 1'b0;
    next_push_data = stack_push_data;
    next_taken = 1'b0;
    next_irq_ack = 1'b0;
    next_wdt_clear = 1'b0;
    unique case (state)
      mie_pkg::ST_HALT:
      begin
        // contents are retained; only a wake resumes the cycle stream
        if (cyc_en && wake)
          next_state = mie_pkg::ST_EXEC;
      end
      mie_pkg::ST_DUMMY:
      begin
        if (cyc_en)
        begin
          next_state = mie_pkg::ST_EXEC;
          if (svc_pending)
          begin
            next_svc_pending = 1'b0;
            next_stack_push = 1'b1;
            next_push_data = pc;
            next_pc = PC_W'(IRQ_VECTOR);
            next_gie = 1'b0;
            next_irq_ack = 1'b1;
          end
        end
      end
      mie_pkg::ST_EXEC:
      begin
        if (go)
        begin
          next_taken = 1'b1;
          next_pc = pc + PC_W'(mie_pkg::PC_STEP);
          next_mem_addr = instr_mem_addr;
          unique case (instr_op)
            mie_pkg::OP_POWERDOWN:
            begin
              next_pdf = 1'b1;
              next_wdt_exp = 1'b0;
              next_wdt_clear = 1'b1;
              next_state = mie_pkg::ST_HALT;
            end
            mie_pkg::OP_INC_MEM:
            begin
              next_mem_we = 1'b1;
              next_mem_wdata = inc_val;
              next_zero = (inc_val == 8'h00);
            end
            mie_pkg::OP_INC_ACC:
            begin
              next_acc = inc_val;
              next_zero = (inc_val == 8'h00);
            end
            mie_pkg::OP_BRANCH:
            begin
              next_pc = instr_addr;
              next_state = mie_pkg::ST_DUMMY;
            end
            mie_pkg::OP_COPY_MEM_ACC: next_acc = mem_rdata;
            mie_pkg::OP_COPY_IMM_ACC: next_acc = instr_imm;
            mie_pkg::OP_COPY_ACC_MEM:
            begin
              next_mem_we = 1'b1;
              next_mem_wdata = acc;
            end
            mie_pkg::OP_UNION_MEM_ACC:
            begin
              next_acc = acc | mem_rdata;
              next_zero = ((acc | mem_rdata) == 8'h00);
            end
            mie_pkg::OP_UNION_IMM_ACC:
            begin
              next_acc = acc | instr_imm;
              next_zero = ((acc | instr_imm) == 8'h00);
            end
            mie_pkg::OP_UNION_INTO_RAM:
            begin
              next_mem_we = 1'b1;
              next_mem_wdata = acc | mem_rdata;
              next_zero = ((acc | mem_rdata) == 8'h00);
            end
            mie_pkg::OP_POP_PC, mie_pkg::OP_POP_PC_IMM:
            begin
              next_pc = stack_top;
              next_stack_pop = 1'b1;
              next_state = mie_pkg::ST_DUMMY;
              if (instr_op == mie_pkg::OP_POP_PC_IMM)
                next_acc = instr_imm;
            end
            mie_pkg::OP_INTERRUPT_EXIT:
            begin
              next_pc = stack_top;
              next_stack_pop = 1'b1;
              next_gie = 1'b1;
              next_state = mie_pkg::ST_DUMMY;
              next_svc_pending = irq_pending;
            end
            mie_pkg::OP_ROTL_MEM:
            begin
              next_mem_we = 1'b1;
              next_mem_wdata = {mem_rdata[6:0], mem_rdata[7]};
            end
            mie_pkg::OP_ROTL_ACC: next_acc = {mem_rdata[6:0], mem_rdata[7]};
            mie_pkg::OP_ROTLC_MEM:
            begin
              next_mem_we = 1'b1;
              next_mem_wdata = {mem_rdata[6:0], carry_flag};
              next_carry = mem_rdata[7];
            end
            mie_pkg::OP_ROTLC_ACC:
            begin
              next_acc = {mem_rdata[6:0], carry_flag};
              next_carry = mem_rdata[7];
            end
            mie_pkg::OP_ROTR_MEM:
            begin
              next_mem_we = 1'b1;
              next_mem_wdata = {mem_rdata[0], mem_rdata[7:1]};
            end
            mie_pkg::OP_ROTR_ACC: next_acc = {mem_rdata[0], mem_rdata[7:1]};
            mie_pkg::OP_ROTRC_MEM:
            begin
              next_mem_we = 1'b1;
              next_mem_wdata = {carry_flag, mem_rdata[7:1]};
              next_carry = mem_rdata[0];
            end
            mie_pkg::OP_ROTRC_ACC:
            begin
              next_acc = {carry_flag, mem_rdata[7:1]};
              next_carry = mem_rdata[0];
            end
            mie_pkg::OP_SUBB_MEM_ACC, mie_pkg::OP_SUBB_IMM_ACC, mie_pkg::OP_SUBB_INTO_RAM:
            begin
              if (sub_dest_ram)
              begin
                next_mem_we = 1'b1;
                next_mem_wdata = sub_diff;
              end
              else
                next_acc = sub_diff;
              next_carry = sub_c;
              next_zero = (sub_diff == 8'h00);
              next_half = sub_h;
              next_wrap = sub_w;
              next_signed = sub_s;
              next_chain = (sub_diff == 8'h00) & chained_zero_flag;
            end
            mie_pkg::OP_DEC_SKIP_MEM, mie_pkg::OP_DEC_SKIP_ACC:
            begin
              if (instr_op == mie_pkg::OP_DEC_SKIP_ACC)
                next_acc = dec_val;
              else
              begin
                next_mem_we = 1'b1;
                next_mem_wdata = dec_val;
              end
              if (dec_val == 8'h00)
              begin
                next_pc = pc + PC_W'(mie_pkg::PC_SKIP_STEP);
                next_state = mie_pkg::ST_DUMMY;
              end
            end
            mie_pkg::OP_FILL_BYTE:
            begin
              next_mem_we = 1'b1;
              next_mem_wdata = mie_pkg::BYTE_ALL_ONES;
            end
            mie_pkg::OP_SET_BIT:
            begin
              next_mem_we = 1'b1;
              next_mem_wdata = mem_rdata | bit_mask;
            end
            // idle and unknown codes only advance
            default: ;
          endcase
        end
      end
      default: next_state = mie_pkg::ST_EXEC;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= mie_pkg::ST_EXEC;
      svc_pending <= 1'b0;
      pc <= '0;
      acc <= mie_pkg::ACC_RESET;
      carry_flag <= 1'b0;
      zero_flag <= 1'b0;
      half_carry_flag <= 1'b0;
      arith_wrap_flag <= 1'b0;
      signed_result_flag <= 1'b0;
      // empty chain counts as zero, else the and-chain could never leave 0
      chained_zero_flag <= 1'b1;
      powerdown_flag <= 1'b0;
      wdt_expired_flag <= 1'b0;
      global_irq_enable <= 1'b0;
    end
    else
    begin
      state <= next_state;
      svc_pending <= next_svc_pending;
      pc <= next_pc;
      acc <= next_acc;
      carry_flag <= next_carry;
      zero_flag <= next_zero;
      half_carry_flag <= next_half;
      arith_wrap_flag <= next_wrap;
      signed_result_flag <= next_signed;
      chained_zero_flag <= next_chain;
      powerdown_flag <= next_pdf;
      wdt_expired_flag <= next_wdt_exp;
      global_irq_enable <= next_gie;
    end
  end

  // strobes other than dummy_cycle and clock_stop are one clock wide, the memory side must act on that edge
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mem_we <= 1'b0;
      mem_addr <= '0;
      mem_wdata <= 8'h00;
      stack_pop <= 1'b0;
      stack_push <= 1'b0;
      stack_push_data <= '0;
      instr_taken <= 1'b0;
      dummy_cycle <= 1'b0;
      clock_stop <= 1'b0;
      wdt_clear <= 1'b0;
      irq_ack <= 1'b0;
    end
    else
    begin
      mem_we <= next_mem_we;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
      stack_pop <= next_stack_pop;
      stack_push <= next_stack_push;
      stack_push_data <= next_push_data;
      instr_taken <= next_taken;
      dummy_cycle <= (next_state == mie_pkg::ST_DUMMY);
      clock_stop <= (next_state == mie_pkg::ST_HALT);
      wdt_clear <= next_wdt_clear;
      irq_ack <= next_irq_ack;
    end
  end

  chk_halt_flags: assert property (@(posedge clk) disable iff (!nrst)
    go && instr_op == mie_pkg::OP_POWERDOWN |=> powerdown_flag && !wdt_expired_flag
      && wdt_clear && clock_stop)
    else $error("power-down did not set flags or halt");

  chk_branch_load: assert property (@(posedge clk) disable iff (!nrst)
    go && instr_op == mie_pkg::OP_BRANCH |=> pc == $past(instr_addr) && dummy_cycle)
    else $error("branch target or dummy cycle missing");

  chk_idle_quiet: assert property (@(posedge clk) disable iff (!nrst)
    go && instr_op == mie_pkg::OP_IDLE |=> pc == $past(pc) + PC_W'(1) && $stable(acc)
      && !mem_we && $stable(carry_flag) && $stable(zero_flag) && !dummy_cycle)
    else $error("idle instruction changed state");

  chk_exit_enable: assert property (@(posedge clk) disable iff (!nrst)
    go && instr_op == mie_pkg::OP_INTERRUPT_EXIT |=> global_irq_enable && stack_pop
      && pc == $past(stack_top))
    else $error("interrupt exit did not pop or enable");

  chk_pending_served: assert property (@(posedge clk) disable iff (!nrst)
    go && instr_op == mie_pkg::OP_INTERRUPT_EXIT && irq_pending
      |-> ##[1:SVC_WAIT] (irq_ack && stack_push && pc == IRQ_VECTOR))
    else $error("pending interrupt not served after exit");

  chk_rotl_carry: assert property (@(posedge clk) disable iff (!nrst)
    go && instr_op == mie_pkg::OP_ROTLC_ACC |=> carry_flag == $past(mem_rdata[7])
      && acc == {$past(mem_rdata[6:0]), $past(carry_flag)} && !mem_we)
    else $error("left rotate through carry wrong");

  chk_sub_carry: assert property (@(posedge clk) disable iff (!nrst)
    go && instr_op == mie_pkg::OP_SUBB_IMM_ACC |=> carry_flag ==
      ({1'b0, $past(acc)} >= ({1'b0, $past(instr_imm)} + {8'h00, !$past(carry_flag)})))
    else $error("subtract carry does not reflect sign");

  chk_dec_skip: assert property (@(posedge clk) disable iff (!nrst)
    go && instr_op == mie_pkg::OP_DEC_SKIP_MEM |=> mem_we
      && (dummy_cycle == (mem_wdata == 8'h00)))
    else $error("decrement skip mismatch");

  chk_fill_byte: assert property (@(posedge clk) disable iff (!nrst)
    go && instr_op == mie_pkg::OP_FILL_BYTE |=> mem_we && mem_wdata == 8'hff
      && $stable(zero_flag) && $stable(carry_flag))
    else $error("fill byte wrong");

  chk_single_cycle: assert property (@(posedge clk) disable iff (!nrst)
    go && instr_op == mie_pkg::OP_UNION_INTO_RAM |=> !dummy_cycle && mem_we
      && mem_wdata == ($past(acc) | $past(mem_rdata)))
    else $error("or into memory wrong or slow");
endmodule // mie_exec

// File: test/mie_far_side.sv
// far-side model: data memory, return stack, pending interrupt
`timescale 1ns/100ps
module mie_far_side (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // data memory
  input wire logic [8:0] instr_mem_addr,
  input wire logic mem_we,
  input wire logic [8:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  // return stack
  input wire logic stack_pop,
  input wire logic stack_push,
  input wire logic [12:0] stack_push_data,
  output logic [12:0] stack_top,
  // interrupt
  input wire logic irq_req,
  input wire logic irq_ack,
  output logic irq_pending
);
  logic [7:0] mem [512];
  logic [12:0] stk [$];
  initial
  begin
    foreach (mem[i])
      mem[i] = 8'h00;
    stack_top = 13'h1555;
  end
  // combinational read, so a write lands before the next take edge
  assign mem_rdata = mem[instr_mem_addr];
  task automatic push(input logic [12:0] v);
    stk.push_back(v);
    stack_top = v;
  endtask
  // empty stack toggles, never holds a stale address steady
  always @(posedge clk)
  begin
    if (mem_we)
      mem[mem_addr] <= mem_wdata;
    if (stack_pop)
      void'(stk.pop_back());
    if (stack_push)
      stk.push_back(stack_push_data);
    stack_top <= stk.size() != 0 ? stk[$] : ~stack_top;
  end
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      irq_pending <= 1'b0;
    else if (irq_ack)
      irq_pending <= 1'b0;
    else if (irq_req)
      irq_pending <= 1'b1;
  end
endmodule // mie_far_side

// File: test/tb.sv
// self-checking bench: execute subset against a behavioural model
`timescale 1ns/100ps
`define CHK(a, b) chk(32'(a), 32'(b))
module tb;
  localparam logic [12:0] VEC = 13'h0004;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] instr_op = 5'h00;
  logic [12:0] instr_addr = 13'h0000;
  logic [8:0] instr_mem_addr = 9'h000;
  logic [7:0] instr_imm = 8'h00;
  logic [2:0] instr_bit = 3'h0;
  logic wake = 1'b0;
  logic irq_req = 1'b0;
  logic [7:0] mem_rdata, acc, mem_wdata, e_acc, e_mem [512];
  logic [12:0] stack_top, pc, stack_push_data, e_pc;
  logic [8:0] mem_addr;
  logic irq_pending, carry_flag, zero_flag, half_carry_flag, arith_wrap_flag;
  logic signed_result_flag, chained_zero_flag, powerdown_flag, wdt_expired_flag;
  logic global_irq_enable, mem_we, stack_pop, stack_push, instr_taken, dummy_cycle;
  logic clock_stop, wdt_clear, irq_ack, e_c, e_z, e_ac, e_ov, e_sc, e_cz, e_pdf, e_to, e_gie;
  logic [15:0] lf = 16'hf0b7;
  longint tp = 0;
  int plen = 0;
  int n_fail = 0;
  int n_tests = 0;
  mie_exec #(.IRQ_VECTOR(VEC)) i_mie_exec (.clk(clk), .nrst(nrst), .instr_valid(1'b1),
    .instr_op(instr_op), .instr_addr(instr_addr), .instr_mem_addr(instr_mem_addr),
    .instr_imm(instr_imm), .instr_bit(instr_bit), .mem_rdata(mem_rdata),
    .stack_top(stack_top), .irq_pending(irq_pending), .wake(wake), .pc(pc), .acc(acc),
    .carry_flag(carry_flag), .zero_flag(zero_flag), .half_carry_flag(half_carry_flag),
    .arith_wrap_flag(arith_wrap_flag), .signed_result_flag(signed_result_flag),
    .chained_zero_flag(chained_zero_flag), .powerdown_flag(powerdown_flag),
    .wdt_expired_flag(wdt_expired_flag), .global_irq_enable(global_irq_enable),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .stack_pop(stack_pop),
    .stack_push(stack_push), .stack_push_data(stack_push_data), .instr_taken(instr_taken),
    .dummy_cycle(dummy_cycle), .clock_stop(clock_stop), .wdt_clear(wdt_clear),
    .irq_ack(irq_ack));
  mie_far_side i_mie_far_side (.clk(clk), .nrst(nrst), .instr_mem_addr(instr_mem_addr),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .stack_pop(stack_pop), .stack_push(stack_push), .stack_push_data(stack_push_data),
    .stack_top(stack_top), .irq_req(irq_req), .irq_ack(irq_ack), .irq_pending(irq_pending));
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic chk(input logic [31:0] a, input logic [31:0] b);
    n_tests++;
    if (a !== b)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, a, b);
    end
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic sub(input logic [7:0] o, output logic [7:0] d);
    logic [8:0] f;
    logic [4:0] h;
    f = {1'b0, e_acc} - {1'b0, o} - {8'h00, ~e_c};
    h = {1'b0, e_acc[3:0]} - {1'b0, o[3:0]} - {4'h0, ~e_c};
    d = f[7:0];
    e_ov = (e_acc[7] ^ o[7]) & (e_acc[7] ^ d[7]);
    e_c = ~f[8];
    e_ac = ~h[4];
    e_sc = d[7] ^ e_ov;
    e_z = d == 8'h00;
    e_cz = e_z & e_cz;
  endtask
  task automatic run(input logic [4:0] op, input logic [8:0] ma, input logic [7:0] imm);
    logic [7:0] m;
    logic [7:0] r;
    logic two;
    int k;
    @(negedge clk);
    lf = lfsr(lf);
    if (op inside {5'h0b, 5'h0c, 5'h0d})
      i_mie_far_side.push(lf[12:0]);
    instr_op = op;
    instr_mem_addr = ma;
    instr_imm = imm;
    instr_bit = lf[15:13];
    instr_addr = ~lf[12:0];
    m = e_mem[ma];
    e_pc = e_pc + 13'h0001;
    case (op)
      5'h01: {e_pdf, e_to} = 2'b10;
      5'h02, 5'h03: r = m + 8'h01;
      5'h04: e_pc = instr_addr;
      5'h05: r = m;
      5'h06, 5'h0c: r = imm;
      5'h07: r = e_acc;
      5'h08, 5'h0a: r = e_acc | m;
      5'h09: r = e_acc | imm;
      5'h0e, 5'h0f: r = {m[6:0], m[7]};
      5'h10, 5'h11: {e_c, r} = {m, e_c};
      5'h12, 5'h13: r = {m[0], m[7:1]};
      5'h14, 5'h15: {r, e_c} = {e_c, m};
      5'h16, 5'h18: sub(m, r);
      5'h17: sub(imm, r);
      5'h19, 5'h1a: r = m - 8'h01;
      5'h1b: r = 8'hff;
      5'h1c: r = m | (8'h01 << instr_bit);
      default: r = 8'h00;
    endcase
    if (op inside {5'h03, 5'h05, 5'h06, 5'h08, 5'h09, 5'h0c, 5'h0f, 5'h11, 5'h13, 5'h15})
      e_acc = r;
    if (op inside {5'h16, 5'h17, 5'h1a})
      e_acc = r;
    if (op inside {5'h02, 5'h07, 5'h0a, 5'h0e, 5'h10, 5'h12, 5'h14, 5'h18, 5'h19, 5'h1b, 5'h1c})
      e_mem[ma] = r;
    if (op inside {5'h02, 5'h03, 5'h08, 5'h09, 5'h0a})
      e_z = r == 8'h00;
    if (op inside {5'h0b, 5'h0c, 5'h0d})
      e_pc = lf[12:0];
    if (op == 5'h0d)
      e_gie = 1'b1;
    two = op inside {5'h04, 5'h0b, 5'h0c, 5'h0d} || (op inside {5'h19, 5'h1a} && r == 8'h00);
    if (op inside {5'h19, 5'h1a} && r == 8'h00)
      e_pc = e_pc + 13'h0001;
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end
    while (instr_taken !== 1'b1 && k < 40);
    `CHK(instr_taken, 1'b1);
    if (plen != 0)
      `CHK(($time - tp) / 20, mie_pkg::CYCLE_DIV * plen);
    tp = $time;
    plen = op == 5'h01 ? 0 : 1 + two;
    `CHK(pc, e_pc);
    `CHK(acc, e_acc);
    `CHK({carry_flag, zero_flag, half_carry_flag}, {e_c, e_z, e_ac});
    `CHK({arith_wrap_flag, signed_result_flag, chained_zero_flag}, {e_ov, e_sc, e_cz});
    `CHK({powerdown_flag, wdt_expired_flag, global_irq_enable}, {e_pdf, e_to, e_gie});
    `CHK({dummy_cycle, wdt_clear}, {two, op == 5'h01});
    @(negedge clk);
    `CHK(i_mie_far_side.mem[ma], e_mem[ma]);
  endtask
  initial
  begin
    forever
      #10 clk = ~clk;
  end
  initial
  begin
    #200000;
    n_fail++;
    report_and_stop();
  end
  initial
  begin
    {e_acc, e_c, e_z, e_ac, e_ov, e_sc, e_cz, e_pdf, e_to, e_gie} = 17'h00008;
    e_pc = 13'h0000;
    foreach (e_mem[i])
      e_mem[i] = 8'h00;
    repeat (6) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    `CHK({pc, acc, powerdown_flag, global_irq_enable, chained_zero_flag}, 24'h000001);
    // decrement to zero skips; accumulator form keeps the byte
    run(5'h06, 9'h003, 8'h01);
    run(5'h07, 9'h003, 8'h00);
    run(5'h19, 9'h003, 8'h00);
    run(5'h1a, 9'h003, 8'h00);
    run(5'h01, 9'h000, 8'h00);
    repeat (12) @(negedge clk);
    `CHK({clock_stop, pc}, {1'b1, e_pc});
    wake = 1'b1;
    run(5'h00, 9'h000, 8'h00);
    wake = 1'b0;
    `CHK(clock_stop, 1'b0);
    irq_req = 1'b1;
    @(negedge clk);
    irq_req = 1'b0;
    run(5'h0d, 9'h000, 8'h00);
    // entry strobes stand for the one clock after the dummy cycle ends
    repeat (3) @(negedge clk);
    `CHK({pc, global_irq_enable, irq_ack, stack_push}, {VEC, 1'b0, 1'b1, 1'b1});
    @(negedge clk);
    `CHK(i_mie_far_side.stk[$], e_pc);
    e_pc = VEC;
    e_gie = 1'b0;
    for (int i = 0; i < 300; i++)
    begin
      lf = lfsr(lf);
      run(lf[4:0] % 29 == 1 ? 5'h00 : 5'(lf[4:0] % 29), {6'h00, lf[7:5]}, lf[15:8]);
    end
    report_and_stop();
  end
endmodule // tb
